// ### include/lsbu_pkg.sv
// Purpose: shared types and constants for the logic, shift and bit-op datapath
// Assumes: one core clock, operands delivered by the decoder with a one-cycle request
// Notes: results come back one clock after the request
package lsbu_pkg;

  localparam int DATA_W = 32;
  localparam int BYTE_MSB = 7;
  localparam int WORD_MSB = 15;
  localparam int LONG_MSB = 31;
  localparam int BITNO_W = 3;
  localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;
  localparam logic [31:0] WORD_MASK = 32'h0000_ffff;
  localparam logic [31:0] LONG_MASK = 32'hffff_ffff;

  typedef enum logic [1:0] {
    LSBU_SZ_BYTE,
    LSBU_SZ_WORD,
    LSBU_SZ_LONG
  } lsbu_size_t;

  typedef enum logic [3:0] {
    LSBU_OP_AND,
    LSBU_OP_OR,
    LSBU_OP_XOR,
    LSBU_OP_NOT,
    LSBU_OP_ARITH_SHIFT_LEFT,
    LSBU_OP_ARITH_SHIFT_RIGHT,
    LSBU_OP_LOGIC_SHIFT_LEFT,
    LSBU_OP_LOGIC_SHIFT_RIGHT,
    LSBU_OP_ROTATE_LEFT,
    LSBU_OP_ROTATE_RIGHT,
    LSBU_OP_ROTATE_LEFT_WITH_CARRY,
    LSBU_OP_ROTATE_RIGHT_WITH_CARRY,
    LSBU_OP_BIT_SET_OP,
    LSBU_OP_BIT_CLEAR_OP
  } lsbu_op_t;

  typedef struct packed {
    lsbu_op_t op;
    lsbu_size_t size;
    logic use_imm;
    logic [DATA_W-1:0] dest;
    logic [DATA_W-1:0] source_register;
    logic [DATA_W-1:0] immediate_operand;
    logic carry_in;
  } lsbu_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic neg;
    logic zero;
    logic carry;
    logic flags_upd;
    logic carry_upd;
  } lsbu_rsp_t;

endpackage

// ### verilog/lsbu_bit_mod.sv
// Purpose: single-bit set/clear on a byte operand
// Assumes: operand is a register low byte or a memory byte fetched by the core
// Notes: purely combinational
`timescale 1ns/1ps
module lsbu_bit_mod
  import lsbu_pkg::*;
(
  input wire logic [BYTE_MSB:0] byte_in,
  input wire logic [BITNO_W-1:0] bit_no,
  input wire logic set_not_clear,
  output logic [BYTE_MSB:0] byte_out
);
  logic [BYTE_MSB:0] sel;
  always_comb begin
    sel = 8'h01 << bit_no;
    if (set_not_clear) begin
      byte_out = byte_in | sel;
    end else begin
      byte_out = byte_in & ~sel;
    end
  end
endmodule // lsbu_bit_mod

// ### verilog/lsbu_core.sv
// Purpose: logic, shift/rotate and bit set/clear execution datapath
// Assumes: decoder holds req stable while req_valid is high for one cycle
// Notes: result, flags and valid are registered, one cycle latency
`timescale 1ns/1ps
module lsbu_core
  import lsbu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire lsbu_req_t req,
  output lsbu_rsp_t rsp_q,
  output logic rsp_valid_q
);

  function automatic logic [DATA_W-1:0] size_mask(input lsbu_size_t sz);
    if (sz == LSBU_SZ_BYTE) begin
      return BYTE_MASK;
    end else if (sz == LSBU_SZ_WORD) begin
      return WORD_MASK;
    end else begin
      return LONG_MASK;
    end
  endfunction

  function automatic int msb_of(input lsbu_size_t sz);
    if (sz == LSBU_SZ_BYTE) begin
      return BYTE_MSB;
    end else if (sz == LSBU_SZ_WORD) begin
      return WORD_MSB;
    end else begin
      return LONG_MSB;
    end
  endfunction

  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] res;
  logic [DATA_W-1:0] merged;
  logic [BYTE_MSB:0] bit_res;
  logic [BITNO_W-1:0] bit_no;
  logic top;
  logic low;
  logic cy;
  logic is_bit;
  int msb;
  lsbu_rsp_t rsp_d;

  // bit number: only the low three bits matter, upper register bits ignored
  assign bit_no = req.use_imm ? req.immediate_operand[BITNO_W-1:0]
                              : req.source_register[BITNO_W-1:0];
  assign is_bit = (req.op == LSBU_OP_BIT_SET_OP) || (req.op == LSBU_OP_BIT_CLEAR_OP);

  lsbu_bit_mod u_bit (
    .byte_in(req.dest[BYTE_MSB:0]),
    .bit_no(bit_no),
    .set_not_clear(req.op == LSBU_OP_BIT_SET_OP),
    .byte_out(bit_res)
  );

  always_comb begin
    mask = size_mask(req.size);
    msb = msb_of(req.size);
    d = req.dest & mask;
    opnd = (req.use_imm ? req.immediate_operand : req.source_register) & mask;
    top = d[msb];
    low = d[0];
    cy = req.carry_in;
    res = d;
    case (req.op)
      LSBU_OP_AND: res = d & opnd;
      LSBU_OP_OR: res = d | opnd;
      LSBU_OP_XOR: res = d ^ opnd;
      LSBU_OP_NOT: res = ~d;
      LSBU_OP_ARITH_SHIFT_LEFT, LSBU_OP_LOGIC_SHIFT_LEFT: begin
        res = d << 1;
        cy = top;
      end
      LSBU_OP_ARITH_SHIFT_RIGHT: begin
        res = d >> 1;
        res[msb] = top;
        cy = low;
      end
      LSBU_OP_LOGIC_SHIFT_RIGHT: begin
        res = d >> 1;
        cy = low;
      end
      LSBU_OP_ROTATE_LEFT: begin
        res = d << 1;
        res[0] = top;
        cy = top;
      end
      LSBU_OP_ROTATE_RIGHT: begin
        res = d >> 1;
        res[msb] = low;
        cy = low;
      end
      LSBU_OP_ROTATE_LEFT_WITH_CARRY: begin
        res = d << 1;
        res[0] = req.carry_in;
        cy = top;
      end
      LSBU_OP_ROTATE_RIGHT_WITH_CARRY: begin
        res = d >> 1;
        res[msb] = req.carry_in;
        cy = low;
      end
      default: res = d;
    endcase
    res = res & mask;
    // upper bits of the destination outside the operand size are preserved
    merged = (req.dest & ~mask) | res;
    if (is_bit) begin
      merged = {req.dest[LONG_MSB:BYTE_MSB+1], bit_res};
    end
    rsp_d.result = merged;
    rsp_d.neg = res[msb];
    rsp_d.zero = (res == '0);
    rsp_d.carry = cy;
    rsp_d.flags_upd = !is_bit;
    rsp_d.carry_upd = (req.op >= LSBU_OP_ARITH_SHIFT_LEFT) && !is_bit;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else if (req_valid) begin
      rsp_q <= rsp_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_valid;
    end
  end

  property p_and_result;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_AND && req.size == LSBU_SZ_LONG)
      |=> (rsp_q.result == ($past(req.dest) & $past(req.use_imm ?
           req.immediate_operand : req.source_register)));
  endproperty
  a_and_result: assert property (p_and_result) else $error("and result wrong");

  property p_or_result;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_OR && req.size == LSBU_SZ_LONG && !req.use_imm)
      |=> (rsp_q.result == ($past(req.dest) | $past(req.source_register)));
  endproperty
  a_or_result: assert property (p_or_result) else $error("or result wrong");

  property p_xor_byte;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_XOR && req.size == LSBU_SZ_BYTE && !req.use_imm)
      |=> (rsp_q.result[BYTE_MSB:0]
           == ($past(req.dest[BYTE_MSB:0]) ^ $past(req.source_register[BYTE_MSB:0])))
          && (rsp_q.result[LONG_MSB:BYTE_MSB+1] == $past(req.dest[LONG_MSB:BYTE_MSB+1]));
  endproperty
  a_xor_byte: assert property (p_xor_byte) else $error("xor byte wrong");

  property p_not_word;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_NOT && req.size == LSBU_SZ_WORD)
      |=> (rsp_q.result[WORD_MSB:0] == ~$past(req.dest[WORD_MSB:0]));
  endproperty
  a_not_word: assert property (p_not_word) else $error("not word wrong");

  property p_sar_byte;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_ARITH_SHIFT_RIGHT && req.size == LSBU_SZ_BYTE)
      |=> (rsp_q.result[BYTE_MSB] == $past(req.dest[BYTE_MSB]))
          && (rsp_q.carry == $past(req.dest[0]));
  endproperty
  a_sar_byte: assert property (p_sar_byte) else $error("arith right wrong");

  property p_rotc_long;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_ROTATE_LEFT_WITH_CARRY && req.size == LSBU_SZ_LONG)
      |=> (rsp_q.result[0] == $past(req.carry_in)) && (rsp_q.carry == $past(req.dest[LONG_MSB]));
  endproperty
  a_rotc_long: assert property (p_rotc_long) else $error("rotate carry wrong");

  property p_bit_set;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_BIT_SET_OP && req.use_imm)
      |=> rsp_q.result[$past(req.immediate_operand[BITNO_W-1:0])] && !rsp_q.flags_upd;
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_bit_clear;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_BIT_CLEAR_OP && !req.use_imm)
      |=> !rsp_q.result[$past(req.source_register[BITNO_W-1:0])];
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

  property p_zero_flag;
    @(posedge ref_clk) disable iff (rst)
    rsp_valid_q && rsp_q.flags_upd |-> (rsp_q.zero == ((rsp_q.result &
      size_mask($past(req.size))) == '0));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  // a logical right shift must bring in zero, never a copy of the sign
  property p_lsr_long;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_LOGIC_SHIFT_RIGHT && req.size == LSBU_SZ_LONG)
      |=> !rsp_q.result[LONG_MSB]
          && (rsp_q.result[LONG_MSB-1:0] == $past(req.dest[LONG_MSB:1]))
          && (rsp_q.carry == $past(req.dest[0]));
  endproperty
  a_lsr_long: assert property (p_lsr_long) else $error("logic right wrong");

  property p_rot_word;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_ROTATE_RIGHT && req.size == LSBU_SZ_WORD)
      |=> (rsp_q.result[WORD_MSB] == $past(req.dest[0]))
          && (rsp_q.result[WORD_MSB-1:0] == $past(req.dest[WORD_MSB:1]))
          && (rsp_q.result[LONG_MSB:WORD_MSB+1] == $past(req.dest[LONG_MSB:WORD_MSB+1]));
  endproperty
  a_rot_word: assert property (p_rot_word) else $error("rotate word wrong");

  property p_neg_flag;
    @(posedge ref_clk) disable iff (rst)
    rsp_valid_q && rsp_q.flags_upd |-> (rsp_q.neg == rsp_q.result[msb_of($past(req.size))]);
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("neg flag wrong");

  // only the low bits of the register may pick the bit, the rest of the byte stays
  property p_bit_set_reg;
    @(posedge ref_clk) disable iff (rst)
    (req_valid && req.op == LSBU_OP_BIT_SET_OP && !req.use_imm)
      |=> (rsp_q.result[BYTE_MSB:0] == ($past(req.dest[BYTE_MSB:0])
           | (8'h01 << $past(req.source_register[BITNO_W-1:0]))));
  endproperty
  a_bit_set_reg: assert property (p_bit_set_reg) else $error("bit set reg wrong");

endmodule // lsbu_core

// ### verification/lsbu_dec_model.sv
// Purpose: decoder and register file stand-in that issues datapath requests
// Assumes: strobe high one cycle per request, or held high for back-to-back requests
// Notes: released request lines carry the inverse of the last value
`timescale 1ns/1ps
module lsbu_dec_model
  import lsbu_pkg::*;
(
  input wire logic ref_clk,
  output logic req_valid,
  output lsbu_req_t req
);
  initial begin
    req_valid = 1'h0;
    req = '0;
  end
  task automatic issue(input lsbu_req_t r);
    @(posedge ref_clk);
    #1;
    req_valid = 1'h1;
    req = r;
    @(posedge ref_clk);
    #1;
    req_valid = 1'h0;
    // stale operands must never pass for fresh ones
    req = ~r;
  endtask
  // raises or keeps the strobe and presents the next request, for back-to-back issue
  task automatic chain(input lsbu_req_t r);
    @(posedge ref_clk);
    #1;
    req_valid = 1'h1;
    req = r;
  endtask
  task automatic release_req();
    @(posedge ref_clk);
    #1;
    req_valid = 1'h0;
    req = ~req;
  endtask
endmodule // lsbu_dec_model

// ### verification/tb.sv
// Purpose: self-checking bench for the logic, shift and bit-op datapath
// Assumes: answer visible just after the edge that takes the request
// Notes: shifts are single-bit, so edge patterns matter more than counts
`timescale 1ns/1ps
module tb
  import lsbu_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic req_valid;
  lsbu_req_t req;
  lsbu_rsp_t rsp_q;
  logic rsp_valid_q;
  int error_cnt = 0;
  int num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  lsbu_dec_model i_dec (.ref_clk(ref_clk), .req_valid(req_valid), .req(req));
  lsbu_core i_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .rsp_q(rsp_q), .rsp_valid_q(rsp_valid_q));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic lsbu_rsp_t ref_rsp(input lsbu_req_t r);
    lsbu_rsp_t e;
    logic [31:0] mk, d, s, v;
    int m;
    m = (r.size == LSBU_SZ_BYTE) ? BYTE_MSB : (r.size == LSBU_SZ_WORD) ? WORD_MSB : LONG_MSB;
    mk = (r.size == LSBU_SZ_BYTE) ? BYTE_MASK : (r.size == LSBU_SZ_WORD) ? WORD_MASK : LONG_MASK;
    d = r.dest & mk;
    s = (r.use_imm ? r.immediate_operand : r.source_register) & mk;
    e = '0;
    e.carry_upd = r.op inside {[LSBU_OP_ARITH_SHIFT_LEFT:LSBU_OP_ROTATE_RIGHT_WITH_CARRY]};
    e.flags_upd = r.op <= LSBU_OP_ROTATE_RIGHT_WITH_CARRY;
    // right-going ops have odd codes, so their outgoing bit is bit 0
    e.carry = e.carry_upd ? (r.op[0] ? d[0] : d[m]) : r.carry_in;
    case (r.op)
      LSBU_OP_AND: v = d & s;
      LSBU_OP_OR: v = d | s;
      LSBU_OP_XOR: v = d ^ s;
      LSBU_OP_NOT: v = ~d;
      LSBU_OP_ARITH_SHIFT_RIGHT: v = (d >> 1) | (d & (32'h1 << m));
      LSBU_OP_LOGIC_SHIFT_RIGHT: v = d >> 1;
      LSBU_OP_ROTATE_LEFT: v = (d << 1) | d[m];
      LSBU_OP_ROTATE_RIGHT: v = (d >> 1) | ({31'h0, d[0]} << m);
      LSBU_OP_ROTATE_LEFT_WITH_CARRY: v = (d << 1) | r.carry_in;
      LSBU_OP_ROTATE_RIGHT_WITH_CARRY: v = (d >> 1) | ({31'h0, r.carry_in} << m);
      default: v = d << 1;
    endcase
    e.result = (r.dest & ~mk) | (v & mk);
    e.neg = e.result[m];
    e.zero = (e.result & mk) == 32'h0;
    if (!e.flags_upd) begin
      e.result = r.dest;
      e.result[s[2:0]] = (r.op == LSBU_OP_BIT_SET_OP);
    end
    return e;
  endfunction

  task automatic do_op(input lsbu_req_t r, output logic [63:0] g, output logic [63:0] x);
    i_dec.issue(r);
    g = 64'({rsp_valid_q, rsp_q});
    x = 64'({1'h1, ref_rsp(r)});
  endtask

  task automatic t_b2b();
    lsbu_req_t a, b;
    a = '0;
    a.op = LSBU_OP_AND;
    a.size = LSBU_SZ_LONG;
    a.dest = 32'hf0f0_0ff0;
    a.source_register = 32'h3c3c_3c3c;
    b = '0;
    b.op = LSBU_OP_ROTATE_RIGHT_WITH_CARRY;
    b.size = LSBU_SZ_WORD;
    b.carry_in = 1'h1;
    b.dest = 32'h1234_8001;
    i_dec.chain(a);
    i_dec.chain(b);
    chk(64'({rsp_valid_q, rsp_q}), 64'({1'h1, ref_rsp(a)}));
    i_dec.release_req();
    chk(64'({rsp_valid_q, rsp_q}), 64'({1'h1, ref_rsp(b)}));
    @(posedge ref_clk);
    #1;
    // answer must stand after the valid pulse has gone
    chk(64'({rsp_valid_q, rsp_q}), 64'({1'h0, ref_rsp(b)}));
  endtask

  task automatic t_reset();
    lsbu_req_t r;
    logic [63:0] g, x;
    r = '0;
    r.op = LSBU_OP_NOT;
    r.size = LSBU_SZ_LONG;
    r.dest = 32'h0f0f_1234;
    do_op(r, g, x);
    chk(g, x);
    rst = 1'h1;
    #1;
    // no stale result may survive a mid-run reset
    chk(64'({rsp_valid_q, rsp_q}), 64'h0);
    repeat (2) @(posedge ref_clk);
    // first request is taken on the first edge after release
    fork
      begin
        @(posedge ref_clk);
        #1;
        rst = 1'h0;
      end
      i_dec.chain(r);
    join
    i_dec.release_req();
    chk(64'({rsp_valid_q, rsp_q}), 64'({1'h1, ref_rsp(r)}));
  endtask

  task automatic t_logic();
    lsbu_req_t r;
    logic [63:0] g, x;
    for (int i = 0; i < 24; i++) begin
      r = '0;
      r.op = lsbu_op_t'(i % 4);
      r.size = lsbu_size_t'(i / 4 % 3);
      r.use_imm = i >= 12;
      r.dest = 32'h8f0f_a5c3;
      r.source_register = 32'h3c5a_ff0f;
      r.immediate_operand = 32'h5a3c_5a3c;
      do_op(r, g, x);
      chk(g, x);
    end
  endtask

  task automatic t_shift();
    lsbu_req_t r;
    logic [63:0] g, x;
    for (int i = 0; i < 48; i++) begin
      r = '0;
      r.op = lsbu_op_t'(4 + i % 8);
      r.size = lsbu_size_t'(i / 8 % 3);
      r.carry_in = i >= 24;
      r.dest = r.carry_in ? 32'h7ffe_7f7e : 32'h8001_8080;
      do_op(r, g, x);
      chk(g, x);
    end
  endtask

  task automatic t_bits();
    lsbu_req_t r;
    logic [63:0] g, x;
    logic [2:0] n;
    for (int i = 0; i < 32; i++) begin
      n = 3'(i / 2);
      r = '0;
      r.op = i[0] ? LSBU_OP_BIT_CLEAR_OP : LSBU_OP_BIT_SET_OP;
      r.use_imm = i >= 16;
      r.dest = i[0] ? 32'habcd_efff : 32'habcd_ef00;
      // high bits set and the unused source pointing elsewhere
      r.immediate_operand = {29'h1fff_ffff, r.use_imm ? n : ~n};
      r.source_register = {29'h1fff_ffff, r.use_imm ? ~n : n};
      do_op(r, g, x);
      chk(g & ~64'h1c, x & ~64'h1c);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    t_logic();
    t_shift();
    t_bits();
    t_b2b();
    t_reset();
    give_verdict();
  end

  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb
